// ==== design/clk_ctrl_regs.svh ====
// Purpose: offsets, fields, reset values and counts of the clock controller
// Assumes: 8-bit register port, byte addresses
// Notes:   definitions only
`ifndef CLK_CTRL_REGS_SVH
`define CLK_CTRL_REGS_SVH

`define CCS_OFFSET       8'h2c
`define TONE_OFFSET      8'h2d
`define IRQ_STAT_OFFSET  8'h2e
`define IRQ_MASK_OFFSET  8'h2f
`define REG_RESET        8'h00

`define CCS_CLKOUT_BIT   7
`define CCS_DIV_HI       6
`define CCS_DIV_LO       5
`define CCS_SLOW_BIT     4
`define CCS_TB_HI        3
`define CCS_TB_LO        2
`define CCS_TIE_BIT      1
`define CCS_FLAG_BIT     0

`define TICK_CYC_0       18'd16000
`define TICK_CYC_1       18'd32000
`define TICK_CYC_2       18'd80000
`define TICK_CYC_3       18'd200000

// half periods of tone at 8 MHz oscillator: 2 kHz, 1 kHz, 500 Hz
`define TONE_HALF_1      14'd2000
`define TONE_HALF_2      14'd4000
`define TONE_HALF_3      14'd8000

`endif

// ==== design/clk_ctrl_pkg.sv ====
// Purpose: types of the clock controller
// Assumes: nothing
// Notes:   numbers live in clk_ctrl_regs.svh
package clk_ctrl_pkg;
    typedef enum logic [1:0] {RUN, LOW_POWER_TICK, FULL_HALT} power_e;
endpackage

// ==== design/main_clock_rtc_beeper.sv ====
// Purpose: core clock select, periodic tick, clock out and tone output
// Assumes: sys_clk is the oscillator clock; one clock domain
// Notes:   core clock divider made as an enable pulse plus a gated level
// Contract
// - clock_out_enable set drives core clock on clockout pin, else pin free.
// - clock out is suspended in low power tick mode.
// - divider select gives oscillator over 2, 4, 8 or 16 in slow mode.
// - slow select zero gives oscillator clock, one gives divided clock.
// - tick period is 16000, 32000, 80000 or 200000 oscillator cycles.
// - a new time base takes effect only after the running period ends.
// - tick irq enable gates tick interrupt; it wakes low power tick mode.
// - halt with tick irq enable enters low power tick mode, not halt.
// - flag set each tick period; a status register read clears it unless a tick sets it in that cycle.
// - tone select: off, about 2 kHz, 1 kHz, 500 Hz, half duty.
// - tone keeps running in low power tick mode.
// - all four registers reset to all zeros.
// - tick interrupt needs enable and inactive cpu mask; wakes wait mode.
// - full halt freezes counters and control and tone register writes until a halt-exit wake.
// - tick interrupt never wakes full halt.
`timescale 1ns/100ps
`include "clk_ctrl_regs.svh"

module main_clock_rtc_beeper
    import clk_ctrl_pkg::*;
#(
    parameter int TICK_SCALE = 1
) (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    input  wire logic       haltReq,
    input  wire logic       haltWake,
    input  wire logic       waitMode,
    input  wire logic       cpuIrqMask,
    output logic            tickIrq,
    output logic            irq,
    output logic            coreClk,
    output logic            coreClkEn,
    output logic            clockoutPinOut,
    output logic            clockoutPinOe,
    output logic            tonePinOut,
    output logic            tonePinOe,
    output logic      [1:0] powerState
);

    // the shortest period must stay at least two cycles once scaled, or
    // the end-of-period compare would never see its last count
    localparam int MIN_TICK  = int'(`TICK_CYC_0);
    localparam int MAX_SCALE = MIN_TICK / 2;

    generate
        if (TICK_SCALE < 1) begin : g_scaleLow
            $error("TICK_SCALE must be at least one");
        end
        if (TICK_SCALE > MAX_SCALE) begin : g_scaleHigh
            $error("TICK_SCALE leaves a tick period under two cycles");
        end
    endgenerate

    logic [7:0]  ccs_q;
    logic [1:0]  tone_q;
    logic [1:0]  tbActive_q;
    logic [17:0] tickCnt_q;
    logic [3:0]  divCnt_q;
    logic [1:0]  divActive_q;
    logic        slowActive_q;
    logic        coreClk_q;
    logic [13:0] toneCnt_q;
    logic        tone_q_out;
    logic [1:0]  irqStat_q;
    logic [1:0]  irqMask_q;
    logic [7:0]  rdata_q;
    power_e      pwr_q;

    // one address compare shared by the write, read and mux decodes
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [7:0] offset);
        return (addr == offset);
    endfunction

    wire hitCcs   = reg_hit(regAddr, `CCS_OFFSET);
    wire hitTone  = reg_hit(regAddr, `TONE_OFFSET);
    wire hitStat  = reg_hit(regAddr, `IRQ_STAT_OFFSET);
    wire hitMask  = reg_hit(regAddr, `IRQ_MASK_OFFSET);

    // in full halt the clock control and tone registers ignore software writes
    wire frozen   = (pwr_q == FULL_HALT);
    wire lowPower = (pwr_q == LOW_POWER_TICK);
    wire wrCcs    = regWr && hitCcs && !frozen;
    wire wrTone   = regWr && hitTone && !frozen;
    wire wrStat   = regWr && hitStat;
    wire wrMask   = regWr && hitMask;
    wire rdCcs    = regRd && hitCcs;
    wire tieBit   = ccs_q[`CCS_TIE_BIT];

    function automatic logic [17:0] tick_len(input logic [1:0] sel);
        logic [17:0] n;
        case (sel)
            2'h0:    n = `TICK_CYC_0;
            2'h1:    n = `TICK_CYC_1;
            2'h2:    n = `TICK_CYC_2;
            default: n = `TICK_CYC_3;
        endcase
        return n / 18'(TICK_SCALE);
    endfunction

    function automatic logic [13:0] tone_half(input logic [1:0] sel);
        logic [13:0] n;
        case (sel)
            2'h1:    n = `TONE_HALF_1;
            2'h2:    n = `TONE_HALF_2;
            default: n = `TONE_HALF_3;
        endcase
        return n;
    endfunction

    // tick counter: period end reloads the time base from software, so a
    // new setting never shortens or stretches the period already running
    wire [17:0] tickLast = tick_len(tbActive_q) - 18'h1;
    wire        tickEnd  = (tickCnt_q == tickLast);
    wire        tickRun  = !frozen;
    wire [1:0]  tbSoft   = ccs_q[`CCS_TB_HI:`CCS_TB_LO];

    always_ff @(posedge sys_clk) begin
        if (rst)
            tickCnt_q <= 18'h0;
        else if (tickRun && tickEnd)
            tickCnt_q <= 18'h0;
        else if (tickRun)
            tickCnt_q <= tickCnt_q + 18'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            tbActive_q <= 2'h0;
        else if (tickRun && tickEnd)
            tbActive_q <= tbSoft;
    end

    // set wins over a read in the same cycle, so a tick landing on the
    // read edge is reported by the next read instead of being lost
    wire       tickEvt  = tickEnd && tickRun;
    wire [7:0] ccsWrVal = {regWdata[7:1], ccs_q[`CCS_FLAG_BIT]};
    wire       flagSet  = tickEvt;
    wire       flagClr  = rdCcs && !flagSet;
    wire       flagNext = flagSet ? 1'b1 :
                          (flagClr ? 1'b0 : ccs_q[`CCS_FLAG_BIT]);

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            ccs_q <= `REG_RESET;
        end else begin
            if (wrCcs)
                ccs_q[7:1] <= ccsWrVal[7:1];
            ccs_q[`CCS_FLAG_BIT] <= flagNext;
        end
    end

    // upper tone bits are reserved and never stored
    always_ff @(posedge sys_clk) begin
        if (rst)
            tone_q <= 2'h0;
        else if (wrTone)
            tone_q <= regWdata[1:0];
    end

    // power state: halt requests pick mode from tick irq enable; the tick
    // only ends low power mode, a full halt needs a halt-exit wake
    wire     tickWake = tickEvt && tieBit;
    wire     goLow    = haltReq && tieBit;
    wire     goHalt   = haltReq && !tieBit;
    wire     lowExit  = tickWake || haltWake;
    wire     haltExit = haltWake;
    power_e  pwr_d;

    always_comb begin
        pwr_d = pwr_q;
        case (pwr_q)
            RUN: begin
                if (goLow)
                    pwr_d = LOW_POWER_TICK;
                else if (goHalt)
                    pwr_d = FULL_HALT;
            end
            LOW_POWER_TICK: begin
                if (lowExit)
                    pwr_d = RUN;
            end
            FULL_HALT: begin
                if (haltExit)
                    pwr_d = RUN;
            end
            default: pwr_d = RUN;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            pwr_q <= RUN;
        else
            pwr_q <= pwr_d;
    end

    // core clock: changes applied only at a divided period end, so no
    // short pulse ever leaves the divider
    // the shift runs at five bits: divide by 16 needs a 1 in bit 4 before
    // the minus one brings the last count back into four bits
    wire [2:0] divShift = {1'b0, divActive_q} + 3'h1;
    wire [4:0] divSpan  = 5'h01 << divShift;
    wire [3:0] divLast  = 4'(divSpan - 5'h01);
    wire [3:0] divHalf  = divLast >> 1;
    wire       divRun   = !frozen;
    wire       divWrap  = !slowActive_q || (divCnt_q == divLast);
    wire       divHigh  = slowActive_q && (divCnt_q <= divHalf);

    always_ff @(posedge sys_clk) begin
        if (rst)
            divCnt_q <= 4'h0;
        else if (divRun && divWrap)
            divCnt_q <= 4'h0;
        else if (divRun)
            divCnt_q <= divCnt_q + 4'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            divActive_q  <= 2'h0;
            slowActive_q <= 1'b0;
        end else if (divRun && divWrap) begin
            divActive_q  <= ccs_q[`CCS_DIV_HI:`CCS_DIV_LO];
            slowActive_q <= ccs_q[`CCS_SLOW_BIT];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst)
            coreClk_q <= 1'b0;
        else if (divRun)
            coreClk_q <= divHigh;
    end

    // normal mode passes the oscillator; slow mode uses divided level
    assign coreClk   = slowActive_q ? coreClk_q : (sys_clk && !frozen);
    assign coreClkEn = divWrap && !frozen;

    // the pin stays enabled while suspended so it does not float to the
    // pull level and look like a clock edge to the far side
    wire clkOutSel  = ccs_q[`CCS_CLKOUT_BIT];
    wire clkOutHold = lowPower || frozen;
    wire clkOutOn   = clkOutSel && !clkOutHold;
    assign clockoutPinOe  = ccs_q[`CCS_CLKOUT_BIT];
    assign clockoutPinOut = clkOutOn ? coreClk : 1'b0;

    // tone: half-period counter toggling the pin, runs in low power mode;
    // the >= compare recovers at once when a shorter pitch is selected
    wire        toneOff  = (tone_q == 2'h0);
    wire [13:0] toneLast = tone_half(tone_q) - 14'h1;
    wire        toneRun  = !frozen;
    wire        toneWrap = (toneCnt_q >= toneLast);

    always_ff @(posedge sys_clk) begin
        if (rst || toneOff)
            toneCnt_q <= 14'h0;
        else if (toneRun && toneWrap)
            toneCnt_q <= 14'h0;
        else if (toneRun)
            toneCnt_q <= toneCnt_q + 14'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst || toneOff)
            tone_q_out <= 1'b0;
        else if (toneRun && toneWrap)
            tone_q_out <= !tone_q_out;
    end
    assign tonePinOut = tone_q_out;
    assign tonePinOe  = (tone_q != 2'h0);

    // tick request to the cpu: level while flag, enable and mask allow
    assign tickIrq = ccs_q[`CCS_FLAG_BIT] && tieBit && !cpuIrqMask;

    // sticky event bits: 0 tick, 1 tone period; write one clears, and an
    // event in the clearing cycle wins so it is never dropped
    wire       toneEvt = tone_q_out && !toneOff && (toneCnt_q == 14'h0);
    wire [1:0] evt     = {toneEvt, tickEvt};
    wire [1:0] statClr = wrStat ? regWdata[1:0] : 2'h0;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_stat
            always_ff @(posedge sys_clk) begin
                if (rst)
                    irqStat_q[gi] <= 1'b0;
                else if (evt[gi])
                    irqStat_q[gi] <= 1'b1;
                else if (statClr[gi])
                    irqStat_q[gi] <= 1'b0;
            end
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (rst)
            irqMask_q <= 2'h0;
        else if (wrMask)
            irqMask_q <= regWdata[1:0];
    end
    assign irq = |(irqStat_q & irqMask_q);

    // unmapped offsets read as zero; data is zero outside the read slot
    // so a stray sample can never show a stale register
    wire [7:0] rdMux =
        hitCcs  ? ccs_q :
        hitTone ? {6'h00, tone_q} :
        hitStat ? {6'h00, irqStat_q} :
        hitMask ? {6'h00, irqMask_q} : 8'h00;

    always_ff @(posedge sys_clk) begin
        if (rst)
            rdata_q <= 8'h00;
        else
            rdata_q <= regRd ? rdMux : 8'h00;
    end
    assign regRdata   = rdata_q;
    assign powerState = pwr_q;

    // waitMode has no effect here; tickIrq still wakes the cpu from it
    wire unusedWait = waitMode;

endmodule

// ==== tb/clk_ctrl_assertions.sv ====
// Purpose: port checks of the clock controller
// Assumes: sync active-high reset, one clock
// Notes:   bound from the testbench top
`timescale 1ns/100ps
module clk_ctrl_checker
    import clk_ctrl_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       rst,
    input wire logic [7:0] regAddr,
    input wire logic       regRd,
    input wire logic [7:0] regRdata,
    input wire logic       haltReq,
    input wire logic       haltWake,
    input wire logic       cpuIrqMask,
    input wire logic       tickIrq,
    input wire logic       coreClk,
    input wire logic       clockoutPinOut,
    input wire logic       clockoutPinOe,
    input wire logic       tonePinOe,
    input wire logic [1:0] powerState
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence statusRd;
        regRd && regAddr == 8'h2c;
    endsequence
    sequence flagRead;
        statusRd ##1 (statusRd and regRdata[0]);
    endsequence
    AST_RESET_ZERO: assert property ($past(rst) |-> regRdata == 8'h00
        && !clockoutPinOe && !tonePinOe && powerState == RUN)
        else $error("outputs not cleared by reset");
    AST_MASK_BLOCKS: assert property (tickIrq |-> !cpuIrqMask)
        else $error("tick interrupt while cpu mask active");
    AST_FLAG_READ: assert property (statusRd and tickIrq |=> regRdata[0])
        else $error("pending flag not returned by read");
    AST_READ_CLEARS: assert property (flagRead |=> !regRdata[0])
        else $error("flag survived a status read");
    AST_HALT_LEAVES: assert property (powerState == RUN && haltReq
        |=> powerState != RUN) else $error("halt request ignored");
    AST_HALT_HOLDS: assert property (powerState == FULL_HALT
        && !haltWake |=> powerState == FULL_HALT)
        else $error("full halt left without wake");
    AST_HALT_WAKES: assert property (powerState == FULL_HALT
        && haltWake |=> powerState == RUN) else $error("wake ignored");
    AST_LP_CLKOUT_OFF: assert property (powerState == LOW_POWER_TICK
        |-> !clockoutPinOut) else $error("clock out active in low power");
    AST_CLKOUT_FOLLOWS: assert property (clockoutPinOe
        && powerState == RUN |-> clockoutPinOut == coreClk)
        else $error("clock out pin not showing core clock");
endmodule

// ==== tb/pin_side_model.sv ====
// Purpose: board side of the clock-out and tone pins
// Assumes: both pins pulled up on the board
// Notes:   a released pin reads high, never the last driven value
`timescale 1ns/100ps
module pin_side_model (
    input  wire logic clockoutPinOut,
    input  wire logic clockoutPinOe,
    input  wire logic tonePinOut,
    input  wire logic tonePinOe,
    output logic      clockoutLevel,
    output logic      toneLevel
);
    assign clockoutLevel = clockoutPinOe ? clockoutPinOut : 1'b1;
    assign toneLevel     = tonePinOe ? tonePinOut : 1'b1;
endmodule

// ==== tb/main_clock_rtc_beeper_tb.sv ====
// Purpose: self-checking bench of the clock controller
// Assumes: tick periods scaled down by SCALE
// Notes:   outputs sampled on the falling edge
`timescale 1ns/100ps
module main_clock_rtc_beeper_tb
    import clk_ctrl_pkg::*;
;
    localparam int SCALE = 50;
    logic sys_clk = 0, rst = 1, regWr = 0, regRd = 0, haltReq = 0;
    logic haltWake = 0, waitMode = 0, cpuIrqMask = 0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata;
    logic tickIrq, irq, coreClk, coreClkEn, clockoutPinOut, clockoutPinOe;
    logic tonePinOut, tonePinOe, clockoutLevel, toneLevel;
    logic [1:0] powerState;
    int nFail = 0, numChecks = 0, cyc = 0;
    int base[4] = '{16000, 32000, 80000, 200000};
    main_clock_rtc_beeper #(.TICK_SCALE(SCALE)) dut (.sys_clk, .rst,
        .regAddr, .regWdata, .regWr, .regRd, .regRdata, .haltReq,
        .haltWake, .waitMode, .cpuIrqMask, .tickIrq, .irq, .coreClk,
        .coreClkEn, .clockoutPinOut, .clockoutPinOe, .tonePinOut,
        .tonePinOe, .powerState);
    pin_side_model pins (.clockoutPinOut, .clockoutPinOe, .tonePinOut,
        .tonePinOe, .clockoutLevel, .toneLevel);
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) cyc <= cyc + 1;
    task summarize;
        $display("checks %0d failures %0d", numChecks, nFail);
        if (nFail == 0 && numChecks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task chk(string nm, logic [31:0] exp, logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            nFail++;
            $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
        end
    endtask
    task wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge sys_clk);
        regWr <= 1'b0;
    endtask
    // two back-to-back reads of one address
    task rd(logic [7:0] a, output logic [7:0] d1, output logic [7:0] d2);
        @(posedge sys_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge sys_clk);
        @(negedge sys_clk);
        d1 = regRdata;
        @(posedge sys_clk);
        regRd <= 1'b0;
        @(negedge sys_clk);
        d2 = regRdata;
    endtask
    task pulse(int w);
        @(posedge sys_clk);
        if (w) haltWake <= 1'b1;
        else haltReq <= 1'b1;
        @(posedge sys_clk);
        haltWake <= 1'b0;
        haltReq <= 1'b0;
        @(negedge sys_clk);
    endtask
    // w=0 waits for the tick interrupt, w=1 for the run state
    task waitHi(int w, output int at);
        int n;
        n = 0;
        while ((w ? powerState !== RUN : tickIrq !== 1'b1) && n < 9000) begin
            @(negedge sys_clk);
            n++;
        end
        if (n == 9000) begin
            nFail++;
            summarize();
        end
        at = cyc;
    endtask
    task t_regs;
        logic [7:0] a, b;
        rd(8'h2c, a, b);
        chk("status", 8'h00, a);
        rd(8'h2d, a, b);
        chk("tone", 8'h00, a);
        rd(8'h40, a, b);
        chk("unmapped", 8'h00, a);
        chk("pinFree", 1, clockoutLevel);
        wr(8'h2c, 8'he2);
        rd(8'h2c, a, b);
        chk("statusRw", 8'he2, a & 8'hfe);
        chk("clkoutOe", 1, clockoutPinOe);
        wr(8'h2d, 8'h03);
        rd(8'h2d, a, b);
        chk("toneRw", 8'h03, a);
        chk("toneOe", 1, tonePinOe);
        wr(8'h2d, 8'h00);
    endtask
    task t_tick;
        logic [7:0] a, b;
        int t0, t1, prev;
        wr(8'h2c, 8'h02);
        waitHi(0, t0);
        @(posedge sys_clk);
        cpuIrqMask <= 1'b1;
        @(negedge sys_clk);
        chk("masked", 0, tickIrq);
        @(posedge sys_clk);
        cpuIrqMask <= 1'b0;
        rd(8'h2c, a, b);
        chk("flagSet", 1, a[0]);
        chk("flagClr", 0, b[0]);
        prev = 0;
        for (int k = 1; k <= 5; k++) begin
            if (k < 5) wr(8'h2c, {4'h0, 2'(k), 2'b10});
            waitHi(0, t1);
            chk("period", base[prev] / SCALE, t1 - t0);
            rd(8'h2c, a, b);
            t0 = t1;
            prev = k % 4;
        end
    endtask
    task t_irq;
        logic [7:0] a, b;
        int t;
        wr(8'h2f, 8'h00);
        wr(8'h2e, 8'hff);
        waitHi(0, t);
        rd(8'h2e, a, b);
        chk("irqStat", 1, a[0]);
        chk("irqMasked", 0, irq);
        wr(8'h2f, 8'h01);
        @(negedge sys_clk);
        chk("irqUp", 1, irq);
        wr(8'h2e, 8'h01);
        @(negedge sys_clk);
        chk("irqCleared", 0, irq);
        rd(8'h2c, a, b);
    endtask
    task t_clk;
        int n;
        for (int k = 0; k < 5; k++) begin
            wr(8'h2c, k < 4 ? {1'b0, 2'(k), 5'h10} : 8'h00);
            // settle past the widest divided period
            repeat (20) @(posedge sys_clk);
            n = 0;
            repeat (64) begin
                @(negedge sys_clk);
                n += int'(coreClkEn);
            end
            chk("coreClkEn", k < 4 ? 32 >> k : 64, n);
        end
    endtask
    task t_power;
        logic [7:0] a, b;
        logic tl;
        int t, n;
        wr(8'h2d, 8'h01);
        wr(8'h2c, 8'h8e);
        waitHi(0, t);
        rd(8'h2c, a, b);
        pulse(0);
        chk("lowPower", LOW_POWER_TICK, powerState);
        chk("clkoutOff", 0, clockoutLevel);
        tl = toneLevel;
        n = 0;
        while (toneLevel === tl && n < 2100) begin
            @(negedge sys_clk);
            n++;
        end
        chk("toneRuns", 1, toneLevel !== tl);
        waitHi(1, t);
        chk("tickWake", RUN, powerState);
        wr(8'h2d, 8'h00);
        wr(8'h2c, 8'h00);
        rd(8'h2c, a, b);
        pulse(0);
        chk("fullHalt", FULL_HALT, powerState);
        wr(8'h2c, 8'h02);
        repeat (400) @(negedge sys_clk);
        chk("haltHolds", FULL_HALT, powerState);
        rd(8'h2c, a, b);
        chk("frozenRegs", 8'h00, a);
        pulse(1);
        chk("haltWake", RUN, powerState);
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        t_regs();
        t_tick();
        t_irq();
        t_clk();
        t_power();
        summarize();
    end
endmodule
bind main_clock_rtc_beeper clk_ctrl_checker checker_i (.sys_clk, .rst,
    .regAddr, .regRd, .regRdata, .haltReq, .haltWake, .cpuIrqMask,
    .tickIrq, .coreClk, .clockoutPinOut, .clockoutPinOe, .tonePinOe,
    .powerState);
